// File: blc_top.sv
// Black level calibration: dark row sequencing, per-path dark filtering and pixel offset correction.
// Assumes a sample stream synchronous to ref_clk, one pixel per valid cycle, rows kernel-aligned.
`timescale 1ns/1ps

module blc_top (
  // Clock, reset and enable
  input  wire logic                        ref_clk,
  input  wire logic                        sys_rst,
  input  wire logic                        clkEn,
  // Register access
  input  wire blc_pkg::blc_reg_req_s       regReq,
  output logic [15:0]                      regRdData,
  // Frame and mode control
  input  wire logic                        frameStart,
  input  wire logic                        rollingShutter,
  input  wire logic [7:0]                  activeRowKernels,
  input  wire logic                        darkRowSync,
  // Sample stream in
  input  wire logic                        sampValid,
  input  wire logic [blc_pkg::PIX_W-1:0]   sampValue,
  // Pixel stream out
  output blc_pkg::blc_pix_s                pixOut,
  output logic                             darkPhase
);

  // Register file.
  logic [15:0] filterCfg_r, filterCfg_nxt;
  logic [15:0] levelCtrl_r, levelCtrl_nxt;
  logic [15:0] rowCfg_r, rowCfg_nxt;
  logic [blc_pkg::NUM_PATHS-1:0] shortfall_r, shortfall_nxt;
  logic [15:0] regRdData_nxt;

  // Frame sequencer.
  blc_pkg::blc_state_e state_r, state_nxt;
  logic [7:0] darkRows_r, darkRows_nxt;
  logic [7:0] rowCnt_r, rowCnt_nxt;
  logic [7:0] kernelCnt_r, kernelCnt_nxt;
  logic [blc_pkg::COL_W-1:0] colCnt_r, colCnt_nxt;
  logic [blc_pkg::KSUM_W-1:0] kSum_r, kSum_nxt;
  logic [blc_pkg::EXP_W-1:0] expEff_r, expEff_nxt;
  logic skipFirst_r, skipFirst_nxt;
  logic [7:0] rowLen;
  logic [blc_pkg::PATH_W-1:0] path;
  logic lastCol, lastKernel;

  // Per-path filter state.
  logic [blc_pkg::ACC_W-1:0] acc_r [blc_pkg::NUM_PATHS];
  logic [blc_pkg::ACC_W-1:0] acc_nxt [blc_pkg::NUM_PATHS];
  logic [blc_pkg::CNT_W-1:0] cnt_r [blc_pkg::NUM_PATHS];
  logic [blc_pkg::CNT_W-1:0] cnt_nxt [blc_pkg::NUM_PATHS];
  logic signed [11:0] pathOff_r [blc_pkg::NUM_PATHS];
  logic signed [11:0] pathOff_nxt [blc_pkg::NUM_PATHS];
  logic [blc_pkg::CNT_W-1:0] needCnt;
  logic [3:0] avgShift;

  // Output stage.
  blc_pkg::blc_pix_s pixOut_nxt;
  logic darkPhase_nxt;
  logic signed [11:0] offSel;
  logic signed [12:0] corr;
  logic [blc_pkg::KSUM_W-1:0] kSumFull;

  // Register file next state.
  always_comb begin
    filterCfg_nxt = filterCfg_r;
    levelCtrl_nxt = levelCtrl_r;
    rowCfg_nxt    = rowCfg_r;
    regRdData_nxt = regRdData;
    if (regReq.wrEn) begin
      case (regReq.addr)
        blc_pkg::ADDR_FILTER_CFG: filterCfg_nxt = regReq.wrData;
        blc_pkg::ADDR_LEVEL_CTRL: levelCtrl_nxt = regReq.wrData;
        blc_pkg::ADDR_ROW_CFG:    rowCfg_nxt    = regReq.wrData;
        default: ;
      endcase
    end
    if (regReq.rdEn) begin
      case (regReq.addr)
        blc_pkg::ADDR_FILTER_CFG: regRdData_nxt = filterCfg_r;
        blc_pkg::ADDR_LEVEL_CTRL: regRdData_nxt = levelCtrl_r;
        blc_pkg::ADDR_SHORTFALL:  regRdData_nxt = {{(16-blc_pkg::NUM_PATHS){1'b0}}, shortfall_r};
        blc_pkg::ADDR_ROW_CFG:    regRdData_nxt = rowCfg_r;
        default:                  regRdData_nxt = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      filterCfg_r <= blc_pkg::FILTER_CFG_RST;
      levelCtrl_r <= blc_pkg::LEVEL_CTRL_RST;
      rowCfg_r    <= blc_pkg::ROW_CFG_RST;
      regRdData   <= 16'h0000;
    end else if (clkEn) begin
      filterCfg_r <= filterCfg_nxt;
      levelCtrl_r <= levelCtrl_nxt;
      rowCfg_r    <= rowCfg_nxt;
      regRdData   <= regRdData_nxt;
    end
  end

  // Position within the row; kernels map to data paths in turn.
  always_comb begin
    rowLen     = (state_r == blc_pkg::ST_DARK && !rollingShutter) ? blc_pkg::GS_ROW_KERNELS
                                                                  : activeRowKernels;
    path       = kernelCnt_r[blc_pkg::PATH_W-1:0];
    lastCol    = (colCnt_r == blc_pkg::COL_W'(blc_pkg::KERNEL_COLS - 1));
    lastKernel = (kernelCnt_r >= rowLen - 8'h01);
    kSumFull   = kSum_r + blc_pkg::KSUM_W'(sampValue);
    needCnt    = blc_pkg::CNT_W'(1) << expEff_r;
    // The shift is one bit wider than the exponent so deep filters cannot wrap it.
    avgShift   = 4'(expEff_r) + 4'(blc_pkg::KSUM_SHIFT);
  end

  // Frame sequencer and dark filter next state.
  always_comb begin
    state_nxt     = state_r;
    darkRows_nxt  = darkRows_r;
    rowCnt_nxt    = rowCnt_r;
    kernelCnt_nxt = kernelCnt_r;
    colCnt_nxt    = colCnt_r;
    kSum_nxt      = kSum_r;
    expEff_nxt    = expEff_r;
    skipFirst_nxt = skipFirst_r;
    shortfall_nxt = shortfall_r;
    for (int p = 0; p < blc_pkg::NUM_PATHS; p++) begin
      acc_nxt[p]     = acc_r[p];
      cnt_nxt[p]     = cnt_r[p];
      pathOff_nxt[p] = pathOff_r[p];
    end
    if (frameStart) begin
      // A count of zero would wrap to 256 rows, so it runs as one row.
      if (darkRowSync) begin
        darkRows_nxt = (rowCfg_r[blc_pkg::ROWS_LSB +: 8] == 8'h00) ? 8'h01
                                                                    : rowCfg_r[blc_pkg::ROWS_LSB +: 8];
      end
      // Without sync the previous count stays in use.
      skipFirst_nxt = rowCfg_r[blc_pkg::SKIP_BIT];
      expEff_nxt    = '0;
      for (int e = 0; e < 8; e++) begin
        if (e <= int'(filterCfg_r[blc_pkg::SAMPLES_LSB +: blc_pkg::EXP_W]) &&
            (16'h0001 << e) <= {9'h000, blc_pkg::GS_ROW_KERNELS[7:1]} &&
            (rollingShutter == 1'b0 || (16'h0001 << e) <= {9'h000, activeRowKernels[7:1]})) begin
          expEff_nxt = blc_pkg::EXP_W'(e);
        end
      end
      for (int p = 0; p < blc_pkg::NUM_PATHS; p++) begin
        acc_nxt[p] = '0;
        cnt_nxt[p] = '0;
      end
      rowCnt_nxt    = '0;
      kernelCnt_nxt = '0;
      colCnt_nxt    = '0;
      kSum_nxt      = '0;
      state_nxt     = blc_pkg::ST_DARK;
    end else begin
      case (state_r)
        blc_pkg::ST_IDLE: ;
        blc_pkg::ST_DARK: begin
          if (sampValid) begin
            colCnt_nxt = colCnt_r + blc_pkg::COL_W'(1);
            kSum_nxt   = lastCol ? '0 : kSumFull;
            if (lastCol) begin
              // One filter sample is the sum of a whole kernel.
              if (!(skipFirst_r && rowCnt_r == 8'h00) && cnt_r[path] < needCnt) begin
                acc_nxt[path] = acc_r[path] + blc_pkg::ACC_W'(kSumFull);
                cnt_nxt[path] = cnt_r[path] + blc_pkg::CNT_W'(1);
              end
              kernelCnt_nxt = lastKernel ? 8'h00 : kernelCnt_r + 8'h01;
              if (lastKernel) begin
                rowCnt_nxt = rowCnt_r + 8'h01;
                if (rowCnt_r >= darkRows_r - 8'h01) begin
                  state_nxt = blc_pkg::ST_CALC;
                end
              end
            end
          end
        end
        blc_pkg::ST_CALC: begin
          for (int p = 0; p < blc_pkg::NUM_PATHS; p++) begin
            // Dividing by the clamped count needCnt keeps the shift fixed; a short path is flagged.
            pathOff_nxt[p] = $signed({4'h0, filterCfg_r[blc_pkg::TARGET_LSB +: 8]}) -
                             $signed({2'b00, 10'(acc_r[p] >> avgShift)});
            shortfall_nxt[p] = (cnt_r[p] < needCnt);
          end
          kernelCnt_nxt = '0;
          colCnt_nxt    = '0;
          state_nxt     = blc_pkg::ST_IMAGE;
        end
        blc_pkg::ST_IMAGE: begin
          if (sampValid) begin
            colCnt_nxt = colCnt_r + blc_pkg::COL_W'(1);
            if (lastCol) begin
              kernelCnt_nxt = lastKernel ? 8'h00 : kernelCnt_r + 8'h01;
            end
          end
        end
        default: state_nxt = blc_pkg::ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_r     <= blc_pkg::ST_IDLE;
      darkRows_r  <= blc_pkg::ROW_CFG_RST[7:0];
      rowCnt_r    <= '0;
      kernelCnt_r <= '0;
      colCnt_r    <= '0;
      kSum_r      <= '0;
      expEff_r    <= '0;
      skipFirst_r <= 1'b0;
      shortfall_r <= '0;
      for (int p = 0; p < blc_pkg::NUM_PATHS; p++) begin
        acc_r[p]     <= '0;
        cnt_r[p]     <= '0;
        pathOff_r[p] <= '0;
      end
    end else if (clkEn) begin
      state_r     <= state_nxt;
      darkRows_r  <= darkRows_nxt;
      rowCnt_r    <= rowCnt_nxt;
      kernelCnt_r <= kernelCnt_nxt;
      colCnt_r    <= colCnt_nxt;
      kSum_r      <= kSum_nxt;
      expEff_r    <= expEff_nxt;
      skipFirst_r <= skipFirst_nxt;
      shortfall_r <= shortfall_nxt;
      for (int p = 0; p < blc_pkg::NUM_PATHS; p++) begin
        acc_r[p]     <= acc_nxt[p];
        cnt_r[p]     <= cnt_nxt[p];
        pathOff_r[p] <= pathOff_nxt[p];
      end
    end
  end

  // Output correction.
  always_comb begin
    if (levelCtrl_r[blc_pkg::AUTO_BIT]) begin
      offSel = pathOff_r[path];
    end else if (levelCtrl_r[blc_pkg::MAN_SIGN_BIT]) begin
      offSel = -$signed({3'b000, levelCtrl_r[blc_pkg::MAN_OFF_LSB +: blc_pkg::MAN_OFF_W]});
    end else begin
      offSel = $signed({3'b000, levelCtrl_r[blc_pkg::MAN_OFF_LSB +: blc_pkg::MAN_OFF_W]});
    end
    corr = $signed({3'b000, sampValue}) + 13'(offSel);
    pixOut_nxt       = '0;
    darkPhase_nxt    = (state_nxt == blc_pkg::ST_DARK);
    pixOut_nxt.value = sampValue;
    case (state_r)
      blc_pkg::ST_DARK: begin
        pixOut_nxt.dark  = 1'b1;
        pixOut_nxt.valid = sampValid && !(skipFirst_r && rowCnt_r == 8'h00);
      end
      blc_pkg::ST_CALC, blc_pkg::ST_IMAGE: begin
        pixOut_nxt.valid = sampValid;
        if (corr < 13'sd0) begin
          pixOut_nxt.value = '0;
        end else if (corr > $signed({3'b000, blc_pkg::PIX_MAX})) begin
          pixOut_nxt.value = blc_pkg::PIX_MAX;
        end else begin
          pixOut_nxt.value = corr[blc_pkg::PIX_W-1:0];
        end
      end
      default: pixOut_nxt.valid = 1'b0;
    endcase
    // Frame start takes priority, so a sample arriving with it never leaks out.
    if (frameStart) begin
      pixOut_nxt.valid = 1'b0;
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      pixOut    <= '0;
      darkPhase <= 1'b0;
    end else if (clkEn) begin
      pixOut    <= pixOut_nxt;
      darkPhase <= darkPhase_nxt;
    end
  end

endmodule

// File: blc_pkg.sv
// Constants, register map and carrier types for the black level calibration block.
// Assumes a 10-bit pixel path split over four output data paths, one kernel per path in turn.
package blc_pkg;

  localparam int PIX_W        = 10;
  localparam int NUM_PATHS    = 4;
  localparam int PATH_W       = 2;
  localparam int KERNEL_COLS  = 8;
  localparam int COL_W        = 3;
  localparam int ACC_W        = 22;
  localparam int KSUM_W       = 13;
  localparam int CNT_W        = 8;
  localparam int EXP_W        = 3;
  localparam int KSUM_SHIFT   = 3;

  localparam logic [PIX_W-1:0] PIX_MAX        = 10'h3FF;
  localparam logic [7:0]       GS_ROW_KERNELS = 8'hA0;

  // Register offsets.
  localparam logic [8:0] ADDR_FILTER_CFG = 9'h080;
  localparam logic [8:0] ADDR_LEVEL_CTRL = 9'h081;
  localparam logic [8:0] ADDR_SHORTFALL  = 9'h088;
  localparam logic [8:0] ADDR_ROW_CFG    = 9'h0C5;

  // Field positions.
  localparam int TARGET_LSB   = 0;
  localparam int SAMPLES_LSB  = 8;
  localparam int AUTO_BIT     = 0;
  localparam int MAN_OFF_LSB  = 1;
  localparam int MAN_OFF_W    = 9;
  localparam int MAN_SIGN_BIT = 10;
  localparam int ROWS_LSB     = 0;
  localparam int SKIP_BIT     = 8;

  // Reset values.
  localparam logic [15:0] FILTER_CFG_RST = 16'h0320;
  localparam logic [15:0] LEVEL_CTRL_RST = 16'h0001;
  localparam logic [15:0] ROW_CFG_RST    = 16'h0108;

  typedef enum logic [3:0] {
    ST_IDLE  = 4'b0001,
    ST_DARK  = 4'b0010,
    ST_CALC  = 4'b0100,
    ST_IMAGE = 4'b1000
  } blc_state_e;

  typedef struct packed {
    logic             valid;
    logic             dark;
    logic [PIX_W-1:0] value;
  } blc_pix_s;

  typedef struct packed {
    logic        wrEn;
    logic        rdEn;
    logic [8:0]  addr;
    logic [15:0] wrData;
  } blc_reg_req_s;

endpackage

// File: blc_properties.sv
// Port checker for the black level calibration block.
// Assumes it is bound to blc_top and sees only that module's ports.
`timescale 1ns/1ps
module blc_properties (
  // Clock and reset
  input wire logic                      ref_clk,
  input wire logic                      sys_rst,
  input wire logic                      clkEn,
  // Register access
  input wire blc_pkg::blc_reg_req_s     regReq,
  input wire logic [15:0]               regRdData,
  // Streams
  input wire logic                      frameStart,
  input wire logic                      sampValid,
  input wire logic [blc_pkg::PIX_W-1:0] sampValue,
  input wire blc_pkg::blc_pix_s         pixOut,
  input wire logic                      darkPhase
);
  logic [15:0]        ctrl_r, ctrl_nxt;
  logic [9:0]         expPix_r, expPix_nxt;
  logic signed [11:0] expSum;

  // A shadow of the level control register lets manual results be predicted from the ports alone.
  always_comb begin
    ctrl_nxt = ctrl_r;
    if (clkEn && regReq.wrEn && regReq.addr == blc_pkg::ADDR_LEVEL_CTRL) begin
      ctrl_nxt = regReq.wrData;
    end
    expSum = {2'b00, sampValue} + {3'b000, ctrl_r[9:1]};
    if (ctrl_r[10]) begin
      expSum = {2'b00, sampValue} - {3'b000, ctrl_r[9:1]};
    end
    expPix_nxt = expSum[9:0];
    if (expSum < 0) begin
      expPix_nxt = '0;
    end else if (expSum > 12'sh3FF) begin
      expPix_nxt = blc_pkg::PIX_MAX;
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ctrl_r   <= blc_pkg::LEVEL_CTRL_RST;
      expPix_r <= '0;
    end else if (clkEn) begin
      ctrl_r   <= ctrl_nxt;
      expPix_r <= expPix_nxt;
    end
  end

  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  sequence s_darkHold;
    darkPhase [*8];
  endsequence
  property p_darkHold;
    frameStart && clkEn |=> s_darkHold;
  endproperty
  a_darkHold: assert property (p_darkHold) else $error("dark phase ended early");
  property p_frameDrop;
    frameStart && clkEn |=> !pixOut.valid;
  endproperty
  a_frameDrop: assert property (p_frameDrop) else $error("sample taken at frame start");
  property p_validCause;
    pixOut.valid |-> $past(sampValid);
  endproperty
  a_validCause: assert property (p_validCause) else $error("pixel without sample");
  property p_rawDark;
    pixOut.valid && pixOut.dark |-> pixOut.value == $past(sampValue);
  endproperty
  a_rawDark: assert property (p_rawDark) else $error("dark pixel altered");
  property p_darkInPhase;
    pixOut.valid && pixOut.dark |-> $past(darkPhase);
  endproperty
  a_darkInPhase: assert property (p_darkInPhase) else $error("dark pixel outside dark rows");
  property p_manual;
    pixOut.valid && !pixOut.dark && !$past(ctrl_r[0]) |-> pixOut.value == expPix_r;
  endproperty
  a_manual: assert property (p_manual) else $error("manual offset result wrong");
  property p_readCtrl;
    regReq.rdEn && clkEn && regReq.addr == blc_pkg::ADDR_LEVEL_CTRL |=> regRdData == $past(ctrl_r);
  endproperty
  a_readCtrl: assert property (p_readCtrl) else $error("level control read wrong");
  property p_rdStands;
    !$past(regReq.rdEn) |-> $stable(regRdData);
  endproperty
  a_rdStands: assert property (p_rdStands) else $error("read data moved");
endmodule

bind blc_top blc_properties u_props (
  .ref_clk    (ref_clk),
  .sys_rst    (sys_rst),
  .clkEn      (clkEn),
  .regReq     (regReq),
  .regRdData  (regRdData),
  .frameStart (frameStart),
  .sampValid  (sampValid),
  .sampValue  (sampValue),
  .pixOut     (pixOut),
  .darkPhase  (darkPhase)
);

// File: blc_rx_model.sv
// Pixel receiver model at the far side of the output stream.
// Assumes the bench clears it at each frame start.
`timescale 1ns/1ps
module blc_rx_model (
  // Clock and clear
  input wire logic                       ref_clk,
  input wire logic                       rxClr,
  // Pixel stream
  input wire blc_pkg::blc_pix_s          pixOut,
  // Frame statistics
  output int                             darkCnt,
  output int                             imgCnt,
  output logic [blc_pkg::PIX_W-1:0]      lastImg
);
  // Counts are per frame so one frame's fault cannot hide in the next.
  always @(posedge ref_clk) begin
    if (rxClr) begin
      darkCnt <= 0;
      imgCnt <= 0;
    end else if (pixOut.valid && pixOut.dark) begin
      darkCnt <= darkCnt + 1;
    end else if (pixOut.valid) begin
      imgCnt <= imgCnt + 1;
      lastImg <= pixOut.value;
    end
  end
endmodule

// File: black_level_calibration_tb.sv
// Self-checking bench for blc_top with a receiver model.
// Assumes the package, design, model and bound checker compile first.
`timescale 1ns/1ps
module black_level_calibration_tb;
  logic                  ref_clk = 0, sys_rst = 1, clkEn = 1;
  blc_pkg::blc_reg_req_s regReq = '0;
  logic [15:0]           regRdData;
  logic                  frameStart = 0, rollingShutter = 1, darkRowSync = 1, sampValid = 0, rxClr = 0;
  logic [7:0]            activeRowKernels = 8'h04;
  logic [9:0]            sampValue = '0, lastImg;
  blc_pkg::blc_pix_s     pixOut;
  logic                  darkPhase;
  int                    darkCnt, imgCnt, errors = 0, n_compared = 0;

  blc_top DUT (.ref_clk(ref_clk), .sys_rst(sys_rst), .clkEn(clkEn), .regReq(regReq), .regRdData(regRdData),
    .frameStart(frameStart), .rollingShutter(rollingShutter), .activeRowKernels(activeRowKernels),
    .darkRowSync(darkRowSync), .sampValid(sampValid), .sampValue(sampValue), .pixOut(pixOut),
    .darkPhase(darkPhase));
  blc_rx_model u_rx (.ref_clk(ref_clk), .rxClr(rxClr), .pixOut(pixOut), .darkCnt(darkCnt),
    .imgCnt(imgCnt), .lastImg(lastImg));

  initial begin
    forever #25 ref_clk = ~ref_clk;
  end

  task automatic chk(input string what, input logic [15:0] e, input logic [15:0] g);
    n_compared++;
    if (g !== e) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic wr(input logic [8:0] a, input logic [15:0] d);
    @(negedge ref_clk);
    regReq.wrEn = 1;
    regReq.addr = a;
    regReq.wrData = d;
    @(negedge ref_clk);
    regReq.wrEn = 0;
  endtask
  task automatic rd(input logic [8:0] a, input logic [15:0] e);
    @(negedge ref_clk);
    regReq.rdEn = 1;
    regReq.addr = a;
    @(negedge ref_clk);
    regReq.rdEn = 0;
    chk($sformatf("register %h", a), e, regRdData);
  endtask
  // Dark samples sit at 0x040, so the auto offset is the 0x020 target minus 0x040, which is -0x020.
  task automatic frame(input int n, input logic [9:0] iv, input logic [9:0] ex, input int nd);
    @(negedge ref_clk);
    frameStart = 1;
    rxClr = 1;
    // The sample that meets frame start must be dropped, not leak out as an image pixel.
    sampValid = 1;
    sampValue = 10'h040;
    @(negedge ref_clk);
    frameStart = 0;
    rxClr = 0;
    repeat (n) @(negedge ref_clk);
    sampValid = 0;
    @(negedge ref_clk);
    sampValid = 1;
    sampValue = iv;
    repeat (32) @(negedge ref_clk);
    sampValid = 0;
    repeat (3) @(negedge ref_clk);
    chk("dark count", 16'(nd), 16'(darkCnt));
    chk("image count", 16'h0020, 16'(imgCnt));
    chk("image value", {6'h00, ex}, {6'h00, lastImg});
  endtask

  task automatic t_regs;
    rd(blc_pkg::ADDR_FILTER_CFG, blc_pkg::FILTER_CFG_RST);
    rd(blc_pkg::ADDR_LEVEL_CTRL, blc_pkg::LEVEL_CTRL_RST);
    rd(blc_pkg::ADDR_ROW_CFG, blc_pkg::ROW_CFG_RST);
    wr(blc_pkg::ADDR_SHORTFALL, 16'hFFFF);
    rd(blc_pkg::ADDR_SHORTFALL, 16'h0000);
    rd(9'h000, 16'h0000);
  endtask
  task automatic t_auto;
    wr(blc_pkg::ADDR_ROW_CFG, 16'h0102);
    frame(64, 10'h100, 10'h100, 32);
    rd(blc_pkg::ADDR_SHORTFALL, 16'h000F);
    wr(blc_pkg::ADDR_ROW_CFG, 16'h0104);
    frame(128, 10'h100, 10'h0E0, 96);
    rd(blc_pkg::ADDR_SHORTFALL, 16'h0000);
    frame(128, 10'h010, 10'h000, 96);
    wr(blc_pkg::ADDR_FILTER_CFG, 16'h0050);
    frame(128, 10'h100, 10'h110, 96);
    wr(blc_pkg::ADDR_FILTER_CFG, blc_pkg::FILTER_CFG_RST);
  endtask
  task automatic t_rows;
    darkRowSync = 0;
    wr(blc_pkg::ADDR_ROW_CFG, 16'h0001);
    frame(128, 10'h100, 10'h0E0, 128);
    darkRowSync = 1;
    frame(32, 10'h100, 10'h100, 32);
    rd(blc_pkg::ADDR_SHORTFALL, 16'h000F);
    rollingShutter = 0;
    frame(1280, 10'h100, 10'h0E0, 1280);
    rd(blc_pkg::ADDR_SHORTFALL, 16'h0000);
    rollingShutter = 1;
  endtask
  task automatic t_manual;
    wr(blc_pkg::ADDR_ROW_CFG, 16'h0104);
    wr(blc_pkg::ADDR_LEVEL_CTRL, 16'h0060);
    frame(128, 10'h3F0, 10'h3FF, 96);
    frame(128, 10'h100, 10'h130, 96);
    wr(blc_pkg::ADDR_LEVEL_CTRL, 16'h0461);
    frame(128, 10'h100, 10'h0E0, 96);
    wr(blc_pkg::ADDR_LEVEL_CTRL, 16'h0460);
    frame(128, 10'h020, 10'h000, 96);
    // A write while the clock enable is low must not land.
    clkEn = 0;
    wr(blc_pkg::ADDR_LEVEL_CTRL, 16'h0001);
    clkEn = 1;
    rd(blc_pkg::ADDR_LEVEL_CTRL, 16'h0460);
  endtask

  task automatic test_done;
    $display("Compared %0d, errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  initial begin
    repeat (16) @(posedge ref_clk);
    @(negedge ref_clk);
    sys_rst = 0;
    t_regs();
    t_auto();
    t_rows();
    t_manual();
    test_done();
  end
endmodule
